// *** hw/wdr_top.sv ***
// one-time enabled watchdog with reset-out pulse on the reset pin
// assumes clk is the oscillator, the cpu drives the register port and mode inputs on clk,
// and the external interrupt pins are asynchronous
//
// How it works
// - the watchdog leaves reset disabled and is enabled only by writing 1E then E1 to the service register at A6.
// - once enabled the 14-bit counter advances once per machine cycle while the oscillator runs.
// - software cannot disable it; only hardware reset or its own overflow reset clears the enable.
// - the 1E then E1 sequence on an enabled watchdog clears the counter.
// - reaching 16383 resets the whole device.
// - overflow drives the reset pin high for 98 oscillator periods.
// - the service register is write-only and the counter can be neither read nor written.
// - in power-down the oscillator stops, so the counter stops and needs no service.
// - power-down is left only by hardware reset or by a low level on an external interrupt enabled before entry.
// - after a wake by interrupt the counter stays stopped until that interrupt line is high again.
// - with idle stop clear the counter keeps running in idle.
// - with idle stop set the counter holds during idle and resumes from that value.
// - with reset-out disable clear the pin is driven after a timeout, with it set the pin is input only.
`timescale 1ns/10ps
`include "wdr_regs.svh"

module wdr_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic idle_mode,
  input wire logic pdown_enter,
  input wire logic ext_irq_zero_en,
  input wire logic ext_irq_one_en,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic chip_reset,
  output logic powered_down
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  wdr_pkg::wdr_state_type state_q;
  logic [3:0] mc_div_q;
  logic mc_tick_q;
  logic [`WDR_CNT_W-1:0] cnt_q;
  logic en_q;
  logic armed_q;
  logic idle_stop_q;
  logic rto_dis_q;
  logic [6:0] rst_out_q;
  logic chip_reset_q;
  logic pin_drive_q;
  logic [7:0] rdata_q;
  logic pd_en0_q;
  logic pd_en1_q;
  logic wake_by_one_q;
  logic [1:0] irq0_sync_q;
  logic [1:0] irq1_sync_q;
  logic [1:0] rst_pin_sync_q;
  logic powered_down_q;

  logic svc_wr;
  logic key_first;
  logic key_second;
  logic kick;
  logic count_ok;
  logic ovf;
  logic irq0_lvl;
  logic irq1_lvl;

  // pins are asynchronous to clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq0_sync_q <= 2'h3;
      irq1_sync_q <= 2'h3;
    end else begin
      irq0_sync_q <= {irq0_sync_q[0], ext_irq_zero};
      irq1_sync_q <= {irq1_sync_q[0], ext_irq_one};
    end
  end

  assign irq0_lvl = irq0_sync_q[1];
  assign irq1_lvl = irq1_sync_q[1];

  // pin level kept for visibility of a held reset, not used by the counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_pin_sync_q <= 2'h0;
    end else begin
      rst_pin_sync_q <= {rst_pin_sync_q[0], rst_pin_i};
    end
  end

  // device is held in reset while the reset-out pulse runs, so writes are dropped then
  assign svc_wr = reg_wr && hit(reg_addr, `WDR_SERVICE_ADDR) && !chip_reset_q;
  assign key_first = svc_wr && (reg_wdata == `WDR_KEY_FIRST);
  assign key_second = svc_wr && (reg_wdata == `WDR_KEY_SECOND) && armed_q;
  assign kick = key_second;

  // idle alone does not stop counting
  assign count_ok = en_q && mc_tick_q && (state_q == wdr_pkg::WDR_RUN) && !(idle_mode && idle_stop_q);
  // overflow on the tick that reaches 16383
  assign ovf = count_ok && !kick && (cnt_q == (`WDR_OVF_VAL - 14'h0001));

  // oscillator stopped in power-down, so the divider freezes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mc_div_q <= 4'h0;
      mc_tick_q <= 1'b0;
    end else if (state_q == wdr_pkg::WDR_PDOWN) begin
      mc_tick_q <= 1'b0;
    end else begin
      mc_tick_q <= (mc_div_q == `WDR_MC_LAST);
      mc_div_q <= (mc_div_q == `WDR_MC_LAST) ? 4'h0 : mc_div_q + 4'h1;
    end
  end

  // two-byte unlock, any other service write breaks it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (ovf || chip_reset_q) begin
      armed_q <= 1'b0;
    end else if (svc_wr) begin
      armed_q <= key_first;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
    end else if (ovf) begin
      en_q <= 1'b0;
    end else if (key_second) begin
      en_q <= 1'b1;
    end
  end

  // no software path loads the counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (ovf || kick) begin
      cnt_q <= '0;
    end else if (count_ok) begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end

  // config bits return to default with the overflow reset of the device
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {idle_stop_q, rto_dis_q} <= `WDR_AUX_RESET;
    end else if (ovf) begin
      {idle_stop_q, rto_dis_q} <= `WDR_AUX_RESET;
    end else if (reg_wr && hit(reg_addr, `WDR_AUX_ADDR) && !chip_reset_q) begin
      idle_stop_q <= reg_wdata[`WDR_AUX_IDLE_BIT];
      rto_dis_q <= reg_wdata[`WDR_AUX_RTO_BIT];
    end
  end

  // disable bit sampled at the overflow, before it is cleared
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_out_q <= 7'h00;
      chip_reset_q <= 1'b0;
      pin_drive_q <= 1'b0;
    end else if (ovf) begin
      rst_out_q <= 7'(`WDR_RST_OUT_CYC - 1);
      chip_reset_q <= 1'b1;
      pin_drive_q <= !rto_dis_q;
    end else if (rst_out_q != 7'h00) begin
      rst_out_q <= rst_out_q - 7'h01;
    end else begin
      chip_reset_q <= 1'b0;
      pin_drive_q <= 1'b0;
    end
  end

  // leave power-down only on an enabled low interrupt
  // then hold until that line is high again
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= wdr_pkg::WDR_RUN;
      powered_down_q <= 1'b0;
      pd_en0_q <= 1'b0;
      pd_en1_q <= 1'b0;
      wake_by_one_q <= 1'b0;
    end else begin
      case (state_q)
        wdr_pkg::WDR_RUN: begin
          if (pdown_enter && !chip_reset_q) begin
            state_q <= wdr_pkg::WDR_PDOWN;
            powered_down_q <= 1'b1;
            pd_en0_q <= ext_irq_zero_en;
            pd_en1_q <= ext_irq_one_en;
          end
        end
        wdr_pkg::WDR_PDOWN: begin
          if (pd_en0_q && !irq0_lvl) begin
            state_q <= wdr_pkg::WDR_WAKE_HOLD;
            powered_down_q <= 1'b0;
            wake_by_one_q <= 1'b0;
          end else if (pd_en1_q && !irq1_lvl) begin
            state_q <= wdr_pkg::WDR_WAKE_HOLD;
            powered_down_q <= 1'b0;
            wake_by_one_q <= 1'b1;
          end
        end
        wdr_pkg::WDR_WAKE_HOLD: begin
          if (wake_by_one_q ? irq1_lvl : irq0_lvl) begin
            state_q <= wdr_pkg::WDR_RUN;
          end
        end
        default: begin
          state_q <= wdr_pkg::WDR_RUN;
          powered_down_q <= 1'b0;
        end
      endcase
    end
  end

  // service register reads as zero, counter not mapped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= 8'h00;
      if (hit(reg_addr, `WDR_AUX_ADDR)) begin
        rdata_q[`WDR_AUX_IDLE_BIT] <= idle_stop_q;
        rdata_q[`WDR_AUX_RTO_BIT] <= rto_dis_q;
      end else if (hit(reg_addr, `WDR_STATUS_ADDR)) begin
        rdata_q[`WDR_ST_EN_BIT] <= en_q;
        rdata_q[`WDR_ST_ARMED_BIT] <= armed_q;
        rdata_q[`WDR_ST_PDOWN_BIT] <= (state_q == wdr_pkg::WDR_PDOWN);
        rdata_q[`WDR_ST_HOLD_BIT] <= (state_q == wdr_pkg::WDR_WAKE_HOLD);
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign rst_pin_o = pin_drive_q;
  assign rst_pin_oe = pin_drive_q;
  assign chip_reset = chip_reset_q;
  // registered copy of the state decode so the output comes from a flop
  assign powered_down = powered_down_q;

  // helper: length of the pin pulse
  logic [6:0] oe_len_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oe_len_q <= 7'h00;
    end else if (pin_drive_q) begin
      oe_len_q <= oe_len_q + 7'h01;
    end else begin
      oe_len_q <= 7'h00;
    end
  end

  property p_no_soft_enable;
    @(posedge clk) disable iff (reset)
    (!en_q && !key_second) |=> !en_q;
  endproperty
  a_no_soft_enable: assert property (p_no_soft_enable) else $error("watchdog enabled without unlock");

  property p_count_step;
    @(posedge clk) disable iff (reset)
    (count_ok && !kick && !ovf) |=> (cnt_q == $past(cnt_q) + 14'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_stay_enabled;
    @(posedge clk) disable iff (reset)
    (en_q && !ovf) |=> en_q;
  endproperty
  a_stay_enabled: assert property (p_stay_enabled) else $error("watchdog disabled without reset");

  property p_kick_clears;
    @(posedge clk) disable iff (reset)
    kick |=> (cnt_q == '0) && en_q;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("service did not clear counter");

  property p_ovf_resets;
    @(posedge clk) disable iff (reset)
    ovf |=> chip_reset && !en_q ##1 chip_reset;
  endproperty
  a_ovf_resets: assert property (p_ovf_resets) else $error("overflow did not reset device");

  property p_pulse_len;
    @(posedge clk) disable iff (reset)
    $fell(pin_drive_q) |-> (oe_len_q == 7'(`WDR_RST_OUT_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset-out pulse length wrong");

  property p_svc_reads_zero;
    @(posedge clk) disable iff (reset)
    (reg_rd && hit(reg_addr, `WDR_SERVICE_ADDR)) |=> (reg_rdata == 8'h00);
  endproperty
  a_svc_reads_zero: assert property (p_svc_reads_zero) else $error("service register readable");

  property p_pdown_frozen;
    @(posedge clk) disable iff (reset)
    (state_q == wdr_pkg::WDR_PDOWN) |=> $stable(cnt_q) && !mc_tick_q;
  endproperty
  a_pdown_frozen: assert property (p_pdown_frozen) else $error("counter moved in power-down");

  property p_wake_hold;
    @(posedge clk) disable iff (reset)
    (state_q == wdr_pkg::WDR_WAKE_HOLD) && !kick |=> $stable(cnt_q);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("counter ran before interrupt released");

  property p_idle_hold;
    @(posedge clk) disable iff (reset)
    (idle_mode && idle_stop_q && !kick) |=> $stable(cnt_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved in idle with stop set");

  property p_rto_disable;
    @(posedge clk) disable iff (reset)
    (ovf && rto_dis_q) |=> !rst_pin_oe [*8];
  endproperty
  a_rto_disable: assert property (p_rto_disable) else $error("reset pin driven while disabled");

  property p_mc_period;
    @(posedge clk) disable iff (reset || state_q != wdr_pkg::WDR_RUN)
    mc_tick_q |=> !mc_tick_q [*8];
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine tick too frequent");

endmodule : wdr_top

// *** hw/wdr_regs.svh ***
// register map, field positions, reset values and timing counts of the watchdog
// assumes inclusion by bare name from the top module
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH

`define WDR_SERVICE_ADDR 8'hA6
`define WDR_AUX_ADDR 8'h8E
`define WDR_STATUS_ADDR 8'hA5
`define WDR_KEY_FIRST 8'h1E
`define WDR_KEY_SECOND 8'hE1
`define WDR_AUX_RTO_BIT 3
`define WDR_AUX_IDLE_BIT 4
`define WDR_AUX_RESET 2'h0
`define WDR_ST_EN_BIT 0
`define WDR_ST_ARMED_BIT 1
`define WDR_ST_PDOWN_BIT 2
`define WDR_ST_HOLD_BIT 3
`define WDR_CNT_W 14
`define WDR_OVF_VAL 14'h3FFF
`define WDR_MC_LAST 4'hB
`define WDR_OSC_PERIOD_NS 20
`define WDR_CLK_PERIOD_NS 20
`define WDR_RST_OUT_OSC 98
`define WDR_RST_OUT_CYC ((`WDR_RST_OUT_OSC * `WDR_OSC_PERIOD_NS + `WDR_CLK_PERIOD_NS - 1) / `WDR_CLK_PERIOD_NS)

`endif

// *** hw/wdr_pkg.sv ***
// types shared by the watchdog design
// assumes the register header is compiled alongside
package wdr_pkg;

  typedef enum logic [1:0] {
    WDR_RUN,
    WDR_PDOWN,
    WDR_WAKE_HOLD
  } wdr_state_type;

endpackage : wdr_pkg

// *** verif/wdr_cpu_model.sv ***
// cpu-side model: software reaching the watchdog over the register port
// assumes one shared clock and a slave that never stalls
`timescale 1ns/10ps
module wdr_cpu_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released data flips so a stale byte is never mistaken for a new one
    reg_wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg
  task automatic service();
    wr_reg(8'hA6, 8'h1E);
    wr_reg(8'hA6, 8'hE1);
  endtask : service
endmodule : wdr_cpu_model

// *** verif/watchdog_with_reset_out_tb_top.sv ***
// self-checking bench for the watchdog: register port, enable, power-down wake
// assumes the cpu model drives the bus; the full timeout is beyond the run length
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, e, g)
module watchdog_with_reset_out_tb_top;
  logic clk, reset, idle_mode, pdown_enter;
  logic irq0_en, irq1_en, irq0, irq1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, rst_pin_i, rst_pin_o, rst_pin_oe, chip_reset, powered_down;
  int err_total = 0;
  int n_compared = 0;
  // reset pin pulled low unless the block drives it
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : 1'b0;
  always #10 clk = ~clk;
  wdr_cpu_model cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  wdr_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
    .pdown_enter(pdown_enter), .ext_irq_zero_en(irq0_en), .ext_irq_one_en(irq1_en),
    .ext_irq_zero(irq0), .ext_irq_one(irq1), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .chip_reset(chip_reset), .powered_down(powered_down));
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic wait_pd(input logic v);
    int i;
    for (i = 0; i < 12 && powered_down !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (powered_down !== v) begin
      $display("wrong value powered_down wait expected %h seen %h", v, powered_down);
      err_total++;
      finish_test();
    end
  endtask : wait_pd
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    idle_mode = 1'b0;
    pdown_enter = 1'b0;
    irq0_en = 1'b0;
    irq1_en = 1'b0;
    irq0 = 1'b1;
    irq1 = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    cpu.rd_reg(8'hA5, d);
    `CHK("status", 8'h00, d);
    cpu.rd_reg(8'h8E, d);
    `CHK("aux", 8'h00, d);
    cpu.rd_reg(8'hA6, d);
    `CHK("service read", 8'h00, d);
    cpu.rd_reg(8'h00, d);
    `CHK("unmapped", 8'h00, d);
    $display("test reset values done");
    cpu.wr_reg(8'h8E, 8'hFF);
    cpu.rd_reg(8'h8E, d);
    `CHK("aux", 8'h18, d);
    cpu.wr_reg(8'h8E, 8'h00);
    $display("test aux done");
    cpu.wr_reg(8'hA6, 8'h1E);
    cpu.wr_reg(8'hA6, 8'h55);
    cpu.wr_reg(8'hA6, 8'hE1);
    cpu.rd_reg(8'hA5, d);
    `CHK("status broken", 8'h00, d);
    cpu.wr_reg(8'hA6, 8'h1E);
    cpu.rd_reg(8'hA5, d);
    `CHK("status armed", 8'h02, d);
    cpu.wr_reg(8'h8E, 8'h00);
    cpu.wr_reg(8'hA6, 8'hE1);
    cpu.rd_reg(8'hA5, d);
    `CHK("enabled", 1'b1, d[0]);
    $display("test enable done");
    cpu.wr_reg(8'hA6, 8'h00);
    cpu.wr_reg(8'hA5, 8'h00);
    cpu.service();
    cpu.rd_reg(8'hA5, d);
    `CHK("enabled", 1'b1, d[0]);
    cpu.wr_reg(8'h8E, 8'h10);
    idle_mode <= 1'b1;
    repeat (40) @(posedge clk);
    idle_mode <= 1'b0;
    cpu.wr_reg(8'h8E, 8'h00);
    idle_mode <= 1'b1;
    repeat (40) @(posedge clk);
    idle_mode <= 1'b0;
    cpu.rd_reg(8'hA5, d);
    `CHK("enabled idle", 1'b1, d[0]);
    $display("test no disable done");
    cpu.service();
    @(posedge clk);
    irq0_en <= 1'b1;
    pdown_enter <= 1'b1;
    @(posedge clk);
    pdown_enter <= 1'b0;
    #1;
    `CHK("powered_down", 1'b1, powered_down);
    @(posedge clk);
    irq1 <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK("powered_down", 1'b1, powered_down);
    @(posedge clk);
    irq1 <= 1'b1;
    irq0 <= 1'b0;
    wait_pd(1'b0);
    cpu.rd_reg(8'hA5, d);
    `CHK("wake hold", 2'h3, {d[3], d[0]});
    @(posedge clk);
    irq0 <= 1'b1;
    for (int i = 0; i < 10 && d[3] !== 1'b0; i++) cpu.rd_reg(8'hA5, d);
    `CHK("wake hold", 1'b0, d[3]);
    cpu.service();
    irq0_en <= 1'b0;
    irq1_en <= 1'b1;
    pdown_enter <= 1'b1;
    @(posedge clk);
    pdown_enter <= 1'b0;
    irq1 <= 1'b0;
    #1;
    `CHK("powered_down one", 1'b1, powered_down);
    wait_pd(1'b0);
    cpu.rd_reg(8'hA5, d);
    `CHK("wake hold one", 8'h09, d);
    @(posedge clk);
    irq1 <= 1'b1;
    for (int i = 0; i < 10 && d[3] !== 1'b0; i++) cpu.rd_reg(8'hA5, d);
    `CHK("resumed one", 8'h01, d);
    cpu.service();
    $display("test power-down done");
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    cpu.rd_reg(8'hA5, d);
    `CHK("status after reset", 8'h00, d);
    `CHK("pin drive", 8'h00, {rst_pin_o, rst_pin_oe, chip_reset, powered_down});
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : watchdog_with_reset_out_tb_top
